// >>> rtl/cause_flags.sv
// Purpose: sticky reset-cause flags with clear-on-read
// Assumes: events and reads are on aclk
// Notes: an event in the read-clear cycle wins over the clear
`timescale 1ns/10ps
`include "wdctl_cfg.svh"
module cause_flags
  import wdctl_pkg::*;
(
  input wire logic aclk,        // clock
  input wire logic aresetn,     // sync reset, low
  input wire logic ce,          // clock enable
  input wire cause_evt_t evt,   // cause pulses
  input wire logic rd_clr,      // read accepted
  output logic [3:0] flags_q    // por,stop,dog,pin
);
  logic [3:0] flags_d;  // next flags
  // ----------------------------------------
  // next value, events override clear
  // ----------------------------------------
  always_comb begin
    flags_d = rd_clr ? 4'h0 : flags_q;
    if (evt.por || evt.dbg_stop) begin
      flags_d = `FLAGS_POR_VAL;
    end else if (evt.pin_rst) begin
      flags_d = 4'h1;
    end else if (evt.dog_run) begin
      flags_d = 4'h2;
    end else if (evt.dog_stop) begin
      flags_d = 4'h6;
    end else if (evt.gpio_stop) begin
      flags_d = 4'h4;
    end
  end
  // power-on value on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_q <= `FLAGS_POR_VAL;
    else if (ce) flags_q <= flags_d;
  end
endmodule

// >>> rtl/reload_lock.sv
// Purpose: key sequencer guarding reload bytes and the power-down select
// Assumes: one write pulse per accepted bus write
// Notes: any unexpected write drops back to idle, or to LK_KEY1 if it is 55h to the control address
`timescale 1ns/10ps
`include "wdctl_cfg.svh"
module reload_lock
  import wdctl_pkg::*;
(
  input wire logic aclk,          // clock
  input wire logic aresetn,       // sync reset, low
  input wire logic ce,            // clock enable
  input wire logic wr,            // write accepted
  input wire logic [11:0] wr_ofs, // write offset
  input wire logic [7:0] wr_byte, // byte of the first enabled lane
  output logic rl_we,             // reload byte strobe
  output reload_wr_t rl_wr,       // reload byte payload
  output logic pd_we,             // power-down select strobe
  output logic pd_val             // power-down value
);
  lock_state_t st_q, st_d;
  wire is_ctl = wr_ofs == `OFS_CAUSE_CTRL;  // control address
  wire is_key1 = is_ctl && wr_byte == `KEY_FIRST;
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    rl_we = 1'b0;
    rl_wr = '{sel: 2'h0, data: wr_byte};
    pd_we = 1'b0;
    pd_val = 1'b0;
    if (wr) begin
      st_d = is_key1 ? LK_KEY1 : LK_IDLE;  // stray write relocks
      unique case (st_q)
        LK_IDLE: ;
        LK_KEY1: begin
          if (is_ctl && wr_byte == `KEY_SECOND) st_d = LK_OPEN_UP;
        end
        LK_OPEN_UP: begin
          if (wr_ofs == `OFS_RELOAD_UP) begin
            st_d = LK_OPEN_MID;
            rl_we = 1'b1;
          end else if (is_ctl && (wr_byte == `KEY_PD_SET || wr_byte == `KEY_PD_CLR)) begin
            pd_we = 1'b1;
            pd_val = wr_byte == `KEY_PD_SET;
            st_d = LK_IDLE;
          end
        end
        LK_OPEN_MID: begin
          if (wr_ofs == `OFS_RELOAD_MID) begin
            st_d = LK_OPEN_LO;
            rl_we = 1'b1;
            rl_wr.sel = 2'h1;
          end
        end
        LK_OPEN_LO: begin
          if (wr_ofs == `OFS_RELOAD_LO) begin
            st_d = LK_IDLE;
            rl_we = 1'b1;
            rl_wr.sel = 2'h2;
          end
        end
        // unused codes of the 3-bit state fall back to locked
        default: st_d = LK_IDLE;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) st_q <= LK_IDLE;
    else if (ce) st_q <= st_d;
  end
endmodule

// >>> rtl/wdctl_cfg.svh
// Purpose: offsets, field positions, key bytes and reset values of the watchdog control block
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef WDCTL_CFG_SVH
`define WDCTL_CFG_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define OFS_CAUSE_CTRL 12'hff0
`define OFS_RELOAD_UP 12'hff1
`define OFS_RELOAD_MID 12'hff2
`define OFS_RELOAD_LO 12'hff3
// ----------------------------------------
// field positions and keys
// ----------------------------------------
`define BIT_POR 7
`define BIT_STOP 6
`define BIT_DOG 5
`define BIT_PIN 4
`define BIT_HALT_PD 0
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define KEY_PD_SET 8'h81
`define KEY_PD_CLR 8'h00
`define FLAGS_POR_VAL 4'h8
`define PD_RESET_VAL 1'h0
`define RELOAD_RESET_VAL 24'hffffff
`endif

// >>> rtl/wdctl_pkg.sv
// Purpose: shared types of the watchdog control block
// Assumes: nothing
// Notes: constants live in wdctl_cfg.svh
package wdctl_pkg;
  // cause events, one-cycle pulses from the reset and recovery logic
  typedef struct packed {
    logic por;          // power-on or debugger reset
    logic dbg_stop;     // debug pin low out of stop mode
    logic pin_rst;      // external reset pin
    logic dog_run;      // expiry outside stop mode
    logic dog_stop;     // expiry recovers stop mode
    logic gpio_stop;    // pin-change stop recovery
  } cause_evt_t;
  // one register write to the reload path
  typedef struct packed {
    logic [1:0] sel;    // 0 upper, 1 middle, 2 low
    logic [7:0] data;   // byte written
  } reload_wr_t;
  typedef enum logic [2:0] {LK_IDLE, LK_KEY1, LK_OPEN_UP, LK_OPEN_MID, LK_OPEN_LO} lock_state_t;
endpackage

// >>> rtl/wdog_status.sv
// Purpose: watchdog reset-cause status and control register on AXI4-Lite
// Assumes: single clock, cause events are one-cycle pulses on aclk
// Notes: reload bytes are held here so the unlock path has a real target
`timescale 1ns/10ps
`include "wdctl_cfg.svh"
// Notes on behaviour
// - status register at 0xff0 shows causes
// - a read of 0xff0 clears four upper flags
// - 55h then aah unlocks reload bytes
// - key writes leave flag bits unchanged; 81h or 00h after the keys write bit0
// - bit7 set by power-on, cleared dog-stop
// - bit6 set on expiry or pin-change stop recovery, not debug pin
// - bit6 cleared by power-on, running expiry
// - bit5 set on expiry, cleared pin-change
// - bit4 set by reset pin
// - bit0 one stops dog in halt
// - power-on or debugger reset gives 1000
// - debug pin stop reset gives 1000
// - reset pin gives 0001
// - running expiry gives 0010
// - gpio stop recovery gives 0100
// - expiry stop recovery gives 0110
// - upper, middle, low order; stray write relocks
// - 55,aa,81 sets, 55,aa,00 clears select
module wdog_status
  import wdctl_pkg::*;
(
  input wire logic aclk,                 // clock, 200 MHz
  input wire logic aresetn,              // sync reset, low
  input wire logic ce,                   // clock enable, freezes state
  input wire cause_evt_t cause_evt,      // cause pulses from reset logic
  input wire logic in_halt,              // device in stop mode
  input wire logic [11:0] s_axi_awaddr,  // write address
  input wire logic s_axi_awvalid,        // write address valid
  output logic s_axi_awready,            // write address ready
  input wire logic [31:0] s_axi_wdata,   // write data
  input wire logic [3:0] s_axi_wstrb,    // write strobes
  input wire logic s_axi_wvalid,         // write data valid
  output logic s_axi_wready,             // write data ready
  output logic [1:0] s_axi_bresp,        // write response
  output logic s_axi_bvalid,             // write response valid
  input wire logic s_axi_bready,         // write response ready
  input wire logic [11:0] s_axi_araddr,  // read address
  input wire logic s_axi_arvalid,        // read address valid
  output logic s_axi_arready,            // read address ready
  output logic [31:0] s_axi_rdata,       // read data
  output logic [1:0] s_axi_rresp,        // read response
  output logic s_axi_rvalid,             // read data valid
  input wire logic s_axi_rready,         // read data ready
  output logic [23:0] reload_q,          // reload value to the counter
  output logic halt_power_down_select_q, // 1 shuts dog and oscillator in halt
  output logic dog_run_q                 // dog and oscillator enable
);
  // ----------------------------------------
  // write channel capture
  // ----------------------------------------
  logic aw_held_q, w_held_q;     // channel already taken
  logic [11:0] awaddr_q;         // held write address
  logic [7:0] wbyte_q;           // held byte of the first enabled lane
  logic wstrb0_q;                // any lane enabled
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held_q && w_held_q && !s_axi_bvalid;  // both halves present
  wire [11:0] wr_word = {awaddr_q[11:2], 2'h0};          // word-aligned offset
  wire wr_mapped = wr_word == `OFS_CAUSE_CTRL;           // only 0xff0 is a word start
  wire lk_wr = wr_go && wstrb0_q;                         // sequencer sees real writes
  // one register per word: byte offsets ff1..ff3 share the ff0 word,
  // so reload bytes are reached through lanes 1..3 of that word
  logic [1:0] lane_q;            // first enabled byte lane, declared before its first reader
  wire [11:0] lk_ofs = wr_word + {10'h0, lane_q};
  // ----------------------------------------
  // read side
  // ----------------------------------------
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire rd_mapped = {s_axi_araddr[11:2], 2'h0} == `OFS_CAUSE_CTRL;
  wire rd_clr = ce && ar_hs && rd_mapped;
  logic [3:0] flags;  // por, stop, dog, pin
  wire [7:0] status_byte = {flags, 3'h0, halt_power_down_select_q};
  // ----------------------------------------
  // sub-blocks
  // ----------------------------------------
  logic rl_we, pd_we, pd_val;
  reload_wr_t rl_wr;
  cause_flags u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .evt(cause_evt),
    .rd_clr(rd_clr),
    .flags_q(flags)
  );
  reload_lock u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .wr(lk_wr),
    .wr_ofs(lk_ofs),
    .wr_byte(wbyte_q),
    .rl_we(rl_we),
    .rl_wr(rl_wr),
    .pd_we(pd_we),
    .pd_val(pd_val)
  );
  // lane picks the byte written; lane 0 is the control byte itself
  wire [1:0] lane_d = s_axi_wstrb[0] ? 2'h0 : s_axi_wstrb[1] ? 2'h1 : s_axi_wstrb[2] ? 2'h2 : 2'h3;
  wire [7:0] byte_d = s_axi_wdata[8*lane_d +: 8];
  // ----------------------------------------
  // write handshake, either order
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      lane_q <= 2'h0;
    end else if (ce) begin
      if (aw_hs) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (w_hs) begin
        w_held_q <= 1'b1;
        wbyte_q <= byte_d;
        lane_q <= lane_d;
        wstrb0_q <= |s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end
  // ready only while the channel is empty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= !aw_held_q && !aw_hs && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !w_hs && !s_axi_bvalid;
    end
  end
  // write response, slverr for unmapped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // read response: old flags, clear next cycle
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !ar_hs;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mapped ? {reload_q, status_byte} : 32'h0;
        s_axi_rresp <= rd_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // reload bytes and halt select
  // ----------------------------------------
  // key writes never touch the flags; only pd_we reaches bit0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_q <= `RELOAD_RESET_VAL;
      halt_power_down_select_q <= `PD_RESET_VAL;
      dog_run_q <= 1'b1;
    end else if (ce) begin
      if (rl_we) begin
        reload_q[8*(2 - rl_wr.sel) +: 8] <= rl_wr.data;
      end
      if (pd_we) begin
        halt_power_down_select_q <= pd_val;
      end
      dog_run_q <= !(in_halt && halt_power_down_select_q);
    end
  end
endmodule

// >>> verif/wdog_status_asserts.sv
// Purpose: port checks of the watchdog status register
// Assumes: ce held high, one clock
// Notes: flags are seen only through read data
`timescale 1ns/10ps
module wdog_status_asserts
  import wdctl_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire cause_evt_t cause_evt, // cause pulses
  input wire logic in_halt, // stop mode
  input wire logic [11:0] s_axi_araddr, // rd address
  input wire logic s_axi_arvalid, // rd addr valid
  input wire logic s_axi_arready, // rd addr ready
  input wire logic [31:0] s_axi_rdata, // rd data
  input wire logic [1:0] s_axi_rresp, // rd response
  input wire logic s_axi_rvalid, // rd valid
  input wire logic s_axi_awvalid, // wr addr valid
  input wire logic s_axi_awready, // wr addr ready
  input wire logic s_axi_wvalid, // wr data valid
  input wire logic s_axi_wready, // wr data ready
  input wire logic s_axi_bvalid, // wr resp valid
  input wire logic [23:0] reload_q, // reload value
  input wire logic halt_power_down_select_q, // halt select
  input wire logic dog_run_q // dog enable
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic clean_q; // status read seen, no cause since
  logic ar_hs; // read address taken
  logic st_rd; // taken read hits the status word
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign st_rd = ar_hs && (s_axi_araddr[11:2] == 10'h3fc);
  // a cause wins over the read, as in the flags
  always_ff @(posedge aclk) begin
    if (!aresetn || (|cause_evt)) begin
      clean_q <= 1'h0;
    end else if (st_rd) begin
      clean_q <= 1'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_read_answer: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered in time");
  a_bad_addr: assert property (ar_hs && s_axi_araddr[11:2] != 10'h3fc |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_clears: assert property (st_rd && clean_q |=> s_axi_rdata[7:4] == 4'h0)
    else $error("flags survived a read");
  a_halt_gate: assert property (in_halt && halt_power_down_select_q |=> !dog_run_q)
    else $error("dog runs in halt with select set");
  a_run_free: assert property (!in_halt |=> dog_run_q)
    else $error("dog stopped outside halt");
  a_reload_write: assert property (!$stable(reload_q) |-> ##[0:1] s_axi_bvalid)
    else $error("reload moved without a write");
  a_select_write: assert property (!$stable(halt_power_down_select_q) |-> ##[0:1] s_axi_bvalid)
    else $error("select moved without a write");
  c_clean_read: cover property (st_rd && clean_q);
  c_halt_off: cover property (in_halt && halt_power_down_select_q);
  c_bad_read: cover property (ar_hs && s_axi_araddr[11:2] != 10'h3fc);
endmodule

// >>> verif/wdog_status_tb.sv
// Purpose: self-checking bench of the watchdog status register
// Assumes: ce held high, byte lanes of word 0xff0 pick the bytes
// Notes: flags are checked through reads only
`timescale 1ns/10ps
module wdog_status_tb import wdctl_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1; // ce tied: freeze not covered
  cause_evt_t cause_evt = '0; // cause pulses
  logic in_halt = 1'h0; // stop mode
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0; // addresses
  logic [31:0] s_axi_wdata = '0, s_axi_rdata; // data
  logic [3:0] s_axi_wstrb = '0; // strobes
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // answers
  logic [1:0] s_axi_bresp, s_axi_rresp; // responses
  logic [23:0] reload_q, rl_exp; // reload seen and expected
  logic halt_power_down_select_q, dog_run_q; // mode outputs
  int err_total = 0, checked = 0; // counters
  wdog_status dut (.aclk, .aresetn, .ce, .cause_evt, .in_halt, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .reload_q, .halt_power_down_select_q, .dog_run_q);
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // master write; address and data offered together, bready held until answer
  task automatic wr(input logic [31:0] d, input logic [3:0] s, input logic [11:0] a = 12'hff0,
    input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    if (n == 50) begin
      chk("write wait", 32'h1, 32'h0);
      wrap_up();
    end
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 50) begin
      chk("read wait", 32'h1, 32'h0);
      wrap_up();
    end
    @(posedge aclk);
  endtask
  // status word: reload bytes above, status byte below
  task automatic rchk(input logic [7:0] st);
    logic [31:0] d;
    logic [1:0] r;
    rd(12'hff0, d, r);
    chk("status word", {rl_exp, st}, d);
    chk("rresp", 32'h0, 32'(r));
  endtask
  task automatic ev(input logic [5:0] e);
    cause_evt <= e;
    @(posedge aclk);
    cause_evt <= '0;
    @(posedge aclk);
  endtask
  task automatic keys;
    wr(32'h55, 4'h1);
    wr(32'haa, 4'h1);
  endtask
  task automatic hchk(input logic run);
    in_halt <= 1'h1;
    repeat (3) @(posedge aclk);
    chk("run in halt", 32'(run), 32'(dog_run_q));
    in_halt <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("run after halt", 32'h1, 32'(dog_run_q));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rl_exp = 24'hffffff;
    rchk(8'h80);
    rchk(8'h00);
    chk("select", 32'h0, 32'(halt_power_down_select_q));
    $display("test reset done");
  endtask
  // single causes, then a second cause on top without a read between
  task automatic t_events;
    logic [5:0] ea[11] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h20, 6'h08, 6'h04, 6'h01, 6'h02};
    logic [5:0] eb[11] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h02, 6'h01, 6'h01, 6'h04, 6'h20};
    logic [3:0] ex[11] = '{4'h8, 4'h8, 4'h1, 4'h2, 4'h6, 4'h4, 4'h6, 4'h4, 4'h4, 4'h2, 4'h8};
    for (int i = 0; i < 11; i++) begin
      ev(ea[i]);
      if (eb[i] != 6'h00) ev(eb[i]);
      rchk({ex[i], 4'h0});
      rchk(8'h00);
    end
    $display("test events done");
  endtask
  task automatic t_unlock;
    ev(6'h08);
    keys();
    wr(32'h0000_1200, 4'h2);
    wr(32'h0034_0000, 4'h4);
    wr(32'h5600_0000, 4'h8);
    rl_exp = 24'h123456;
    chk("reload", 32'(rl_exp), 32'(reload_q));
    rchk(8'h10);
    $display("test unlock done");
  endtask
  // out-of-order byte and a wrong key both relock
  task automatic t_relock;
    logic [31:0] d;
    logic [1:0] r;
    keys();
    wr(32'h0000_7700, 4'h2);
    wr(32'h8800_0000, 4'h8);
    wr(32'h0099_0000, 4'h4);
    wr(32'h55, 4'h1);
    wr(32'h11, 4'h1);
    wr(32'h0000_ee00, 4'h2);
    wr(32'h0, 4'hf, 12'h100, 2'h2);
    rl_exp = 24'h773456;
    chk("reload", 32'(rl_exp), 32'(reload_q));
    rd(12'h100, d, r);
    chk("bad rdata", 32'h0, d);
    chk("bad rresp", 32'h2, 32'(r));
    $display("test relock done");
  endtask
  task automatic t_halt;
    keys();
    wr(32'h81, 4'h1);
    chk("select", 32'h1, 32'(halt_power_down_select_q));
    rchk(8'h01);
    hchk(1'h0);
    keys();
    wr(32'h00, 4'h1);
    chk("select", 32'h0, 32'(halt_power_down_select_q));
    hchk(1'h1);
    chk("reload", 32'(rl_exp), 32'(reload_q));
    $display("test halt done");
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial begin
    t_reset();
    t_events();
    t_unlock();
    t_relock();
    t_halt();
    t_reset();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    chk("run time", 32'h0, 32'h1);
    wrap_up();
  end
endmodule
bind wdog_status wdog_status_asserts chk (.aclk, .aresetn, .cause_evt, .in_halt, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .reload_q, .halt_power_down_select_q, .dog_run_q);
